/* File: dv/cewe_mem_model.sv */
// display memory model: byte array written under byte enables
`timescale 1ns/1ns
module cewe_mem_model (
   input wire logic         clk_i,
   input wire logic [19:0]  addr_i,
   input wire logic [127:0] data_i,
   input wire logic [15:0]  be_i,
   input wire logic         valid_i
);
   // unwritten bytes stay unknown, so a stray read shows at once
   logic [7:0] mem [0:1048575];
   always @(posedge clk_i)
      if (valid_i)
         for (int k = 0; k < 16; k++)
            if (be_i[k])
               mem[20'(addr_i + 20'(k))] <= data_i[8*k +: 8];
endmodule : cewe_mem_model

/* File: dv/cewe_top_sva.sv */
// checker: apb timing, block address and byte enables of the write engine
`timescale 1ns/1ns
module cewe_top_sva (
   input wire logic         ref_clk_i,
   input wire logic         nrst_i,
   input wire logic         psel_i,
   input wire logic         penable_i,
   input wire logic         pwrite_i,
   input wire logic [11:0]  paddr_i,
   input wire logic [31:0]  pwdata_i,
   input wire logic [3:0]   pstrb_i,
   input wire logic [31:0]  prdata_o,
   input wire logic         pready_o,
   input wire logic         pslverr_o,
   input wire logic [19:0]  mem_addr_o,
   input wire logic [127:0] mem_data_o,
   input wire logic [15:0]  mem_byte_en_o,
   input wire logic         mem_valid_o
);
   logic [7:0]  msk_q, ctl_q, md_q, hd_q, on8;
   logic [15:0] ha_q, be16;
   logic        hw_q, wr, hw, x8, x16;
   // register shadows follow apb writes, no access to design internals
   assign wr = psel_i & penable_i & ~pready_o & pwrite_i;
   assign hw = wr & (paddr_i == cewe_pkg::ADDR_HOST_WRITE);
   assign x8 = ctl_q[2] & ~ctl_q[4] & (md_q[2:1] == 2'h2);
   assign x16 = ctl_q[2] & ctl_q[4] & (md_q[2:1] == 2'h2);
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         on8[i] = msk_q[7-i] & (md_q[0] | hd_q[7-i]);
         be16[2*i +: 2] = {2{on8[i]}};
      end
   end
   always_ff @(posedge ref_clk_i or negedge nrst_i)
      if (!nrst_i)
         {msk_q, ctl_q, md_q, hd_q, ha_q, hw_q} <= {8'h0F, 40'h0, 1'h0};
      else
      begin
         hw_q <= hw;
         if (hw)
            {ha_q, hd_q} <= pwdata_i[23:0];
         if (wr & pstrb_i[0] & (paddr_i == cewe_pkg::ADDR_PIXEL_WRITE_MASK))
            msk_q <= pwdata_i[7:0];
         if (wr & pstrb_i[0] & (paddr_i == cewe_pkg::ADDR_MODE_EXTENSION_CTRL))
            ctl_q <= pwdata_i[7:0];
         if (wr & pstrb_i[0] & (paddr_i == cewe_pkg::ADDR_GRAPHICS_WRITE_MODE))
            md_q <= pwdata_i[7:0];
      end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   property p_plain;
      mem_valid_o && !ctl_q[2] && !ctl_q[3] |-> mem_addr_o == {4'h0, ha_q} && mem_byte_en_o == 16'h0001;
   endproperty
   a_plain: assert property (p_plain) else $error("plain write wrong");
   property p_by8;
      mem_valid_o && ctl_q[2] && ctl_q[1] && !ctl_q[4] |-> mem_addr_o == {1'b0, ha_q, 3'h0};
   endproperty
   a_by8: assert property (p_by8) else $error("eight pixel address wrong");
   property p_by16;
      mem_valid_o && ctl_q[2] && ctl_q[4] |-> mem_addr_o == {ha_q, 4'h0};
   endproperty
   a_by16: assert property (p_by16) else $error("sixteen byte address wrong");
   property p_be8;
      mem_valid_o && x8 |-> mem_byte_en_o == {8'h00, on8};
   endproperty
   a_be8: assert property (p_be8) else $error("8bpp enables wrong");
   property p_be16;
      mem_valid_o && x16 |-> mem_byte_en_o == be16;
   endproperty
   a_be16: assert property (p_be16) else $error("16bpp enables wrong");
   property p_latch;
      mem_valid_o && md_q[2:0] == 3'h1 && ctl_q[3] |-> mem_byte_en_o == 16'h00FF;
   endproperty
   a_latch: assert property (p_latch) else $error("latched write enables wrong");
   property p_cause;
      hw_q |-> mem_valid_o && pready_o && !pslverr_o ##1 !mem_valid_o;
   endproperty
   a_cause: assert property (p_cause) else $error("host write pulse wrong");
   property p_only;
      mem_valid_o |-> hw_q;
   endproperty
   a_only: assert property (p_only) else $error("memory write without host write");
   property p_ready;
      $rose(penable_i) && psel_i |=> pready_o ##1 !pready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("pready timing wrong");
   c_fgbg16: cover property (mem_valid_o && x16 && md_q[0]);
   c_fg8: cover property (mem_valid_o && x8 && !md_q[0]);
   c_err: cover property (pslverr_o);
endmodule : cewe_top_sva
bind cewe_top cewe_top_sva i_cewe_top_sva (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_addr_o(mem_addr_o),
   .mem_data_o(mem_data_o), .mem_byte_en_o(mem_byte_en_o), .mem_valid_o(mem_valid_o));

/* File: dv/tb.sv */
// testbench: register access and random expansion writes against a memory model
`timescale 1ns/1ns
module tb;
   logic ref_clk_i, nrst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, mem_valid_o, er;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic [3:0] pstrb_i;
   logic [19:0] mem_addr_o, ea;
   logic [127:0] mem_data_o, ed;
   logic [15:0] mem_byte_en_o, eb, ha;
   logic [7:0] msk, ctl, md, fgl, fgh, bgl, bgh, hd;
   logic [63:0] lat;
   logic [2:0] mtab [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
   int mismatches, n_compared, cyc;
   cewe_top i_cewe_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
      .mem_byte_en_o(mem_byte_en_o), .mem_valid_o(mem_valid_o));
   cewe_mem_model i_cewe_mem_model (.clk_i(ref_clk_i), .addr_i(mem_addr_o), .data_i(mem_data_o),
      .be_i(mem_byte_en_o), .valid_i(mem_valid_o));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // about 44 cycles per random pass (eleven apb calls of four cycles), so this ceiling only trips on a hang
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [127:0] g, input logic [127:0] e);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask : chk
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do
         @(posedge ref_clk_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      er = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
   endtask : apb
   function automatic void expect_wr();
      logic on;
      logic [7:0] lo, hi;
      ea = (ctl[4] & ctl[2]) ? {ha, 4'h0} : (ctl[1] & ctl[2]) ? {1'b0, ha, 3'h0} : {4'h0, ha};
      ed = {120'h0, hd};
      eb = 16'h0001;
      if (md[2:0] == 3'h1 && ctl[3])
      begin
         ed = {64'h0, lat};
         eb = 16'h00FF;
      end
      else if (ctl[2] && md[2:1] == 2'h2)
         for (int i = 0; i < 8; i++)
         begin
            on = msk[7-i] & (md[0] | hd[7-i]);
            lo = hd[7-i] ? fgl : bgl;
            hi = hd[7-i] ? fgh : bgh;
            if (ctl[4])
               {ed[16*i +: 16], eb[2*i +: 2]} = {hi, lo, on, on};
            else
               {ed[8*i +: 8], eb[i]} = {lo, on};
         end
   endfunction : expect_wr
   initial
   begin
      {nrst_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, lat} = '0;
      pstrb_i = 4'hF;
      void'($urandom(32'h6960C85C));
      repeat (16) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, 12'(4 * i), 32'h0);
         chk(rd, (i == 0) ? 32'h0F : 32'h0);
      end
      apb(1'b1, 12'h0FC, 32'hFF);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({er, rd}, {1'b1, 32'h0});
      $display("test registers done");
      for (int t = 0; t < 400; t++)
      begin
         ctl = {3'h0, 4'($urandom), 1'b0};
         md = {5'h0, mtab[$urandom % 4]};
         {msk, fgl, fgh, bgl, bgh} = {$urandom, 8'($urandom)};
         {hd, ha, ed[63:0]} = {24'($urandom), $urandom, $urandom};
         lat = {ctl[3] ? ed[63:32] : lat[63:32], ed[31:0]};
         apb(1'b1, cewe_pkg::ADDR_MODE_EXTENSION_CTRL, {24'h0, ctl});
         apb(1'b1, cewe_pkg::ADDR_GRAPHICS_WRITE_MODE, {24'h0, md});
         apb(1'b1, cewe_pkg::ADDR_PIXEL_WRITE_MASK, {24'h0, msk});
         apb(1'b1, cewe_pkg::ADDR_FOREGROUND_COLOR_LOW, {24'h0, fgl});
         apb(1'b1, cewe_pkg::ADDR_FOREGROUND_COLOR_HIGH, {24'h0, fgh});
         apb(1'b1, cewe_pkg::ADDR_BACKGROUND_COLOR_LOW, {24'h0, bgl});
         apb(1'b1, cewe_pkg::ADDR_BACKGROUND_COLOR_HIGH, {24'h0, bgh});
         apb(1'b1, cewe_pkg::ADDR_LATCH_LOAD_LOW, ed[31:0]);
         apb(1'b1, cewe_pkg::ADDR_LATCH_LOAD_HIGH, ed[63:32]);
         apb(1'b0, cewe_pkg::ADDR_LATCH_LOAD_HIGH, 32'h0);
         chk(rd, lat[63:32]);
         apb(1'b1, cewe_pkg::ADDR_HOST_WRITE, {8'h0, ha, hd});
         expect_wr();
         chk(mem_addr_o, ea);
         chk(mem_byte_en_o, eb);
         @(negedge ref_clk_i);
         for (int k = 0; k < 16; k++)
            if (eb[k])
               chk(i_cewe_mem_model.mem[20'(ea + 20'(k))], ed[8*k +: 8]);
      end
      $display("test random expansion done");
      apb(1'b0, cewe_pkg::ADDR_ENGINE_STATUS, 32'h0);
      chk(rd, {11'h0, ctl[3] & (md[2:0] == 3'h1), ctl[2] & (md[2:0] == 3'h5), ctl[2] & (md[2:0] == 3'h4),
         ctl[2] & ctl[4], ctl[2] & ctl[1] & ~ctl[4], 16'h0190});
      $display("test status done");
      conclude();
   end
endmodule : tb

/* File: verilog/cewe_pkg.sv */
// package: register map, field positions and carrier types of the colour expansion write engine
package cewe_pkg;
   localparam logic [11:0] ADDR_PIXEL_WRITE_MASK      = 12'h000;
   localparam logic [11:0] ADDR_MODE_EXTENSION_CTRL   = 12'h004;
   localparam logic [11:0] ADDR_GRAPHICS_WRITE_MODE   = 12'h008;
   localparam logic [11:0] ADDR_BACKGROUND_COLOR_LOW  = 12'h00C;
   localparam logic [11:0] ADDR_FOREGROUND_COLOR_LOW  = 12'h010;
   localparam logic [11:0] ADDR_BACKGROUND_COLOR_HIGH = 12'h014;
   localparam logic [11:0] ADDR_FOREGROUND_COLOR_HIGH = 12'h018;
   localparam logic [11:0] ADDR_ENGINE_STATUS         = 12'h01C;
   localparam logic [11:0] ADDR_HOST_WRITE            = 12'h020;
   localparam logic [11:0] ADDR_LATCH_LOAD_LOW        = 12'h024;
   localparam logic [11:0] ADDR_LATCH_LOAD_HIGH       = 12'h028;
   localparam int EIGHT_PIXEL_BIT  = 1;
   localparam int EXT_ENABLE_BIT   = 2;
   localparam int WIDE_LATCH_BIT   = 3;
   localparam int SIXTEEN_BIT_BIT  = 4;
   localparam logic [2:0] MODE_FG_ONLY  = 3'h4;
   localparam logic [2:0] MODE_FG_BG    = 3'h5;
   localparam logic [2:0] MODE_LATCHED  = 3'h1;
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   localparam logic [7:0] RESET_MASK    = 8'h0F;
   localparam int SHIFT_EIGHT    = 3;
   localparam int SHIFT_SIXTEEN  = 4;
   localparam int HOST_ADDR_W    = 16;
   localparam int MEM_ADDR_W     = 20;

   typedef struct packed {
      logic [MEM_ADDR_W-1:0] addr;
      logic [127:0]          data;
      logic [15:0]           byte_en;
      logic                  valid;
   } cewe_mem_wr_t;

   typedef struct packed {
      logic [7:0]   pixel_write_mask;
      logic [7:0]   mode_extension_control;
      logic [7:0]   graphics_write_mode;
      logic [7:0]   background_color_low;
      logic [7:0]   foreground_color_low;
      logic [7:0]   background_color_high;
      logic [7:0]   foreground_color_high;
      logic [63:0]  read_latch;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
      logic         access_done;
      logic [15:0]  write_count;
      cewe_mem_wr_t mem_wr;
   } cewe_state_t;
endpackage : cewe_pkg

/* File: verilog/cewe_top.sv */
// top: apb slave and colour expansion write engine
// Notes on behaviour
// - extended modes only while enable bit set
// - mode field 100 fg only, 101 fg/bg
// - eight-pixel addressing shifts address by three
// - sixteen-bit bit overrides eight-pixel addressing
// - sixteen-bit and enable shift address by four
// - 8bpp write updates up to eight bytes
// - 16bpp write updates up to sixteen bytes
// - high bytes from high colour registers
// - pixel mask widens to eight bits
// - 16bpp mask bit gates both pixel bytes
// - latch-width bit gives eight-byte read latches
// - write mode 1 writes all latched bytes (code: only with latch-width bit set, else a plain host byte write)
// - mode 4 8bpp writes foreground low byte
// - mode 4 zero data bit leaves pixel
// - mode 4 16bpp writes 16-bit foreground
// - mode 5 8bpp fg for one, bg zero
// - cleared mask bit suppresses pixel write
// - mode 5 16bpp writes 16-bit fg/bg
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module cewe_top (
   input  wire logic                             ref_clk_i,
   input  wire logic                             nrst_i,
   input  wire logic                             psel_i,
   input  wire logic                             penable_i,
   input  wire logic                             pwrite_i,
   input  wire logic [11:0]                      paddr_i,
   input  wire logic [31:0]                      pwdata_i,
   input  wire logic [3:0]                       pstrb_i,
   output logic      [31:0]                      prdata_o,
   output logic                                  pready_o,
   output logic                                  pslverr_o,
   output logic      [cewe_pkg::MEM_ADDR_W-1:0]  mem_addr_o,
   output logic      [127:0]                     mem_data_o,
   output logic      [15:0]                      mem_byte_en_o,
   output logic                                  mem_valid_o
);
   logic                 rst_meta_q;
   logic                 rst_sync_q;
   cewe_pkg::cewe_state_t s_q;
   cewe_pkg::cewe_state_t s_d;

   // reset released through two flops
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   logic                            ext_en;
   logic                            px16;
   logic                            by8;
   logic                            mode4;
   logic                            mode5;
   logic                            mode1_wide;
   logic                            apb_setup;
   logic                            apb_wr;
   logic                            apb_rd;
   logic                            addr_hit;
   logic [7:0]                      host_data;
   logic [cewe_pkg::HOST_ADDR_W-1:0] host_addr;
   logic [127:0]                    exp_data;
   logic [15:0]                     exp_be;
   wire logic [63:0]                lane8_data;
   wire logic [7:0]                 lane8_be;
   wire logic [127:0]               lane16_data;
   wire logic [15:0]                lane16_be;
   logic [7:0]                      wmask;

   assign ext_en     = s_q.mode_extension_control[cewe_pkg::EXT_ENABLE_BIT];
   assign px16       = ext_en & s_q.mode_extension_control[cewe_pkg::SIXTEEN_BIT_BIT];
   // sixteen-bit enhancement wins; eight-pixel bit is don't care then
   assign by8        = ext_en & s_q.mode_extension_control[cewe_pkg::EIGHT_PIXEL_BIT] & ~px16;
   assign mode4      = ext_en & (s_q.graphics_write_mode[2:0] == cewe_pkg::MODE_FG_ONLY);
   assign mode5      = ext_en & (s_q.graphics_write_mode[2:0] == cewe_pkg::MODE_FG_BG);
   assign mode1_wide = s_q.mode_extension_control[cewe_pkg::WIDE_LATCH_BIT]
                       & (s_q.graphics_write_mode[2:0] == cewe_pkg::MODE_LATCHED);
   // mask is four bits wide outside modes 4 and 5
   assign wmask      = (mode4 | mode5) ? s_q.pixel_write_mask
                                       : {4'h0, s_q.pixel_write_mask[3:0]};
   assign apb_setup  = psel_i & penable_i & ~s_q.access_done;
   assign apb_wr     = apb_setup & pwrite_i;
   assign apb_rd     = apb_setup & ~pwrite_i;
   assign host_data  = pwdata_i[7:0];
   assign host_addr  = pwdata_i[8 +: cewe_pkg::HOST_ADDR_W];

   // per-pixel expansion; bit 7 drives pixel 0 at the lowest address
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_pix
         logic        dbit;
         logic        mbit;
         logic        wr_en;
         logic [15:0] color;
         assign dbit  = host_data[7-gi];
         assign mbit  = wmask[7-gi];
         // cleared mask always blocks; a zero data bit blocks in mode 4 only
         assign wr_en = mbit & (mode5 | dbit);
         assign color = dbit ? {s_q.foreground_color_high, s_q.foreground_color_low}
                             : {s_q.background_color_high, s_q.background_color_low};
         // 8bpp: pixel gi is byte gi; latched write takes latch byte gi
         assign lane8_data[gi*8 +: 8] = mode1_wide ? s_q.read_latch[gi*8 +: 8] : color[7:0];
         assign lane8_be[gi]          = mode1_wide | wr_en;
         // 16bpp: pixel gi at bytes 2gi (low colour) and 2gi+1 (high colour)
         assign lane16_data[gi*16 +: 16] = color;
         assign lane16_be[gi*2 +: 2]     = {2{wr_en}};
      end
   endgenerate
   // separate lane sets per layout, so no byte has two drivers
   assign exp_data = (px16 & ~mode1_wide) ? lane16_data : {64'h0, lane8_data};
   assign exp_be   = (px16 & ~mode1_wide) ? lane16_be : {8'h00, lane8_be};

   always_comb
   begin
      s_d                 = s_q;
      s_d.pready          = 1'b0;
      s_d.pslverr         = 1'b0;
      s_d.mem_wr.valid    = 1'b0;
      // pready one cycle after access phase; done flag blocks a second hit
      s_d.access_done     = apb_setup;
      addr_hit            = 1'b1;
      if (apb_setup)
      begin
         s_d.pready = 1'b1;
      end
      unique case (paddr_i)
         cewe_pkg::ADDR_PIXEL_WRITE_MASK:      s_d.prdata = {24'h0, s_q.pixel_write_mask};
         cewe_pkg::ADDR_MODE_EXTENSION_CTRL:   s_d.prdata = {24'h0, s_q.mode_extension_control};
         cewe_pkg::ADDR_GRAPHICS_WRITE_MODE:   s_d.prdata = {24'h0, s_q.graphics_write_mode};
         cewe_pkg::ADDR_BACKGROUND_COLOR_LOW:  s_d.prdata = {24'h0, s_q.background_color_low};
         cewe_pkg::ADDR_FOREGROUND_COLOR_LOW:  s_d.prdata = {24'h0, s_q.foreground_color_low};
         cewe_pkg::ADDR_BACKGROUND_COLOR_HIGH: s_d.prdata = {24'h0, s_q.background_color_high};
         cewe_pkg::ADDR_FOREGROUND_COLOR_HIGH: s_d.prdata = {24'h0, s_q.foreground_color_high};
         cewe_pkg::ADDR_ENGINE_STATUS:         s_d.prdata = {11'h0, mode1_wide, mode5, mode4, px16, by8,
                                                             s_q.write_count};
         cewe_pkg::ADDR_HOST_WRITE:            s_d.prdata = 32'h0;
         cewe_pkg::ADDR_LATCH_LOAD_LOW:        s_d.prdata = s_q.read_latch[31:0];
         cewe_pkg::ADDR_LATCH_LOAD_HIGH:       s_d.prdata = s_q.read_latch[63:32];
         default:
         begin
            s_d.prdata = 32'h0;
            addr_hit   = 1'b0;
         end
      endcase
      if (apb_rd)
      begin
         s_d.pslverr = ~addr_hit;
      end
      else
      begin
         s_d.prdata = s_q.prdata;
      end
      if (apb_wr)
      begin
         s_d.pslverr = ~addr_hit;
         if (pstrb_i[0])
         begin
            unique case (paddr_i)
               cewe_pkg::ADDR_PIXEL_WRITE_MASK:      s_d.pixel_write_mask       = pwdata_i[7:0];
               cewe_pkg::ADDR_MODE_EXTENSION_CTRL:   s_d.mode_extension_control = pwdata_i[7:0];
               cewe_pkg::ADDR_GRAPHICS_WRITE_MODE:   s_d.graphics_write_mode    = pwdata_i[7:0];
               cewe_pkg::ADDR_BACKGROUND_COLOR_LOW:  s_d.background_color_low   = pwdata_i[7:0];
               cewe_pkg::ADDR_FOREGROUND_COLOR_LOW:  s_d.foreground_color_low   = pwdata_i[7:0];
               cewe_pkg::ADDR_BACKGROUND_COLOR_HIGH: s_d.background_color_high  = pwdata_i[7:0];
               cewe_pkg::ADDR_FOREGROUND_COLOR_HIGH: s_d.foreground_color_high  = pwdata_i[7:0];
               default:
               begin
               end
            endcase
         end
         if (paddr_i == cewe_pkg::ADDR_LATCH_LOAD_LOW)
         begin
            s_d.read_latch[31:0] = pwdata_i;
         end
         // upper half only exists with eight-byte latches
         if (paddr_i == cewe_pkg::ADDR_LATCH_LOAD_HIGH
             && s_q.mode_extension_control[cewe_pkg::WIDE_LATCH_BIT])
         begin
            s_d.read_latch[63:32] = pwdata_i;
         end
         if (paddr_i == cewe_pkg::ADDR_HOST_WRITE)
         begin
            s_d.mem_wr.valid = 1'b1;
            s_d.write_count  = s_q.write_count + 16'h0001;
            if (px16)
            begin
               s_d.mem_wr.addr = {host_addr, 4'h0};
            end
            else if (by8)
            begin
               s_d.mem_wr.addr = {1'b0, host_addr, 3'h0};
            end
            else
            begin
               // standard path: packed-pixel address; plain byte write unless mode 4, mode 5 or wide-latch mode 1
               s_d.mem_wr.addr = {4'h0, host_addr};
            end
            if (mode4 | mode5 | mode1_wide)
            begin
               s_d.mem_wr.data    = exp_data;
               s_d.mem_wr.byte_en = exp_be;
            end
            else
            begin
               s_d.mem_wr.data    = {120'h0, host_data};
               s_d.mem_wr.byte_en = 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         s_q                        <= '0;
         s_q.pixel_write_mask       <= cewe_pkg::RESET_MASK;
         s_q.mode_extension_control <= cewe_pkg::RESET_BYTE;
         s_q.graphics_write_mode    <= cewe_pkg::RESET_BYTE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign prdata_o      = s_q.prdata;
   assign pready_o      = s_q.pready;
   assign pslverr_o     = s_q.pslverr;
   assign mem_addr_o    = s_q.mem_wr.addr;
   assign mem_data_o    = s_q.mem_wr.data;
   assign mem_byte_en_o = s_q.mem_wr.byte_en;
   assign mem_valid_o   = s_q.mem_wr.valid;
endmodule : cewe_top
